/* cpu_interrupt_controller_defines.vh */
// constants of the interrupt priority control block
`ifndef CPU_INTERRUPT_CONTROLLER_DEFINES_VH
`define CPU_INTERRUPT_CONTROLLER_DEFINES_VH
// =====================================================================
// register indexes; the byte address is four times the index
`define IDX_INTERRUPT_CONTROL 8'h00
`define IDX_LEVEL_EXECUTING_FLAGS 8'h01
`define IDX_NORMAL_PRIORITY_POINTER 8'h02
`define IDX_HIGH_PRIORITY_VECTOR 8'h03
`define IDX_UNLOCK_KEY 8'h04
// register byte addresses
`define OFS_INTERRUPT_CONTROL 8'h00
`define OFS_LEVEL_EXECUTING_FLAGS 8'h04
`define OFS_NORMAL_PRIORITY_POINTER 8'h08
`define OFS_HIGH_PRIORITY_VECTOR 8'h0c
`define OFS_UNLOCK_KEY 8'h10
// =====================================================================
// field positions
`define BIT_VECTOR_LOCATION_SELECT 6
`define BIT_COMPACT_TABLE_ENABLE 5
`define BIT_ROUND_ROBIN_ENABLE 0
`define BIT_UNMASKABLE_EXECUTING 7
`define BIT_HIGH_LEVEL_EXECUTING 1
`define BIT_NORMAL_LEVEL_EXECUTING 0
// =====================================================================
// reset values and keys
`define RST_INTERRUPT_CONTROL 8'h00
`define RST_LEVEL_EXECUTING_FLAGS 8'h00
`define RST_NORMAL_PRIORITY_POINTER 8'h00
`define RST_HIGH_PRIORITY_VECTOR 8'h00
`define IO_REGISTER_KEY 8'hd8
`define UNLOCK_WINDOW 3'h4
`define RESET_PC 16'h0000
`define HIGH_DISABLED 8'h00
// =====================================================================
// compact table vector numbers
`define CVT_UNMASKABLE 8'h01
`define CVT_HIGH 8'h02
`define CVT_NORMAL 8'h03
`endif

/* cpu_interrupt_controller.v */
// interrupt priority control registers, arbiter and level tracking
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - key write then protected write within four
// - unlocked-less protected writes are ignored
// - vector select, compact enable need key
// - round robin bit always writable
// - bit 6 picks vector table location
// - location ignored when all boot section
// - reset program counter is 0x0000
// - bit 5 enables compact vector table
// - fixed order counted from the pointer, or round robin
// - unmaskable flag set during its handler
// - high flag held while nested by unmaskable
// - normal flag held while nested above
// - priority pointer at 0x02 steers arbitration
// - high vector at 0x03, zero disables
// - pointer lowest, pointer+1 highest, wrapping
// - round robin loads last acknowledged normal vector
// - compact table uses vectors 1,2,3
// - high request preempts normal handler
module cpu_interrupt_controller (
    input wire CORE_CLK,
    input wire RST,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [7:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire [255:0] IRQ_REQ,
    input wire UNMASKABLE_REQ,
    input wire INSTR_RETIRE,
    input wire INTERRUPT_RETURN,
    input wire CPU_ACK,
    input wire ALL_BOOT,
    output reg IRQ_VALID,
    output reg [7:0] IRQ_VECTOR,
    output reg [7:0] IRQ_SLOT,
    output reg VECTORS_AT_BOOT_START,
    output reg [15:0] RESET_VECTOR_PC
);
`include "cpu_interrupt_controller_defines.vh"
// =====================================================================
// register state
reg [7:0] ctrl_q;
reg [7:0] flags_q;
reg [7:0] pointer_q;
reg [7:0] high_vec_q;
reg [2:0] unlock_q;
reg [7:0] taken_num_q;
reg [255:0] irq_s1_q;
reg [255:0] irq_s2_q;
reg nmi_s1_q;
reg nmi_s2_q;
reg [31:0] rd_word;
// =====================================================================
// address decode
// one register per aligned word, so the low two address bits must be zero
function hits;
    input [7:0] addr;
    input [7:0] idx;
    begin
        hits = (addr[7:2] == idx[5:0]) && (addr[1:0] == 2'b00);
    end
endfunction
wire setup = PSEL & ~PENABLE;
// writes land at the edge where the master sees ready
wire access = PSEL & PENABLE & PREADY;
wire wr = access & PWRITE;
wire rd = setup & ~PWRITE;
wire sel_ctrl = hits(PADDR, `IDX_INTERRUPT_CONTROL);
wire sel_flags = hits(PADDR, `IDX_LEVEL_EXECUTING_FLAGS);
wire sel_ptr = hits(PADDR, `IDX_NORMAL_PRIORITY_POINTER);
wire sel_high = hits(PADDR, `IDX_HIGH_PRIORITY_VECTOR);
wire sel_key = hits(PADDR, `IDX_UNLOCK_KEY);
wire known = sel_ctrl | sel_flags | sel_ptr | sel_high | sel_key;
// =====================================================================
// synchronisers for peripheral requests
// requests come from other clocks, so each bit passes two flops
genvar g;
generate
    for (g = 0; g < 256; g = g + 1) begin : sync_bit
        always @(posedge CORE_CLK or posedge RST) begin
            if (RST) begin
                irq_s1_q[g] <= 1'b0;
                irq_s2_q[g] <= 1'b0;
            end else begin
                irq_s1_q[g] <= IRQ_REQ[g];
                irq_s2_q[g] <= irq_s1_q[g];
            end
        end
    end
endgenerate
// =====================================================================
// unmaskable request synchroniser
always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
        nmi_s1_q <= 1'b0;
        nmi_s2_q <= 1'b0;
    end else begin
        nmi_s1_q <= UNMASKABLE_REQ;
        nmi_s2_q <= nmi_s1_q;
    end
end
// =====================================================================
// arbitration
// vectors 0 and 1 are reset and unmaskable, never normal
function [7:0] pick_normal;
    input [255:0] req;
    input [7:0] ptr;
    input [7:0] hv;
    integer i;
    reg found;
    reg [7:0] cand;
    begin
        found = 1'b0;
        pick_normal = 8'h00;
        for (i = 1; i <= 256; i = i + 1) begin
            cand = ptr + i[7:0];
            if (!found && cand > 8'h01 && cand != hv && req[cand]) begin
                found = 1'b1;
                pick_normal = cand;
            end
        end
    end
endfunction
// both modes count from the pointer
// pointer zero gives the plain lowest-first order
wire [7:0] eff_ptr = pointer_q;
wire [7:0] normal_win = pick_normal(irq_s2_q, eff_ptr, high_vec_q);
wire normal_pend = (normal_win != 8'h00);
wire high_pend = (high_vec_q != `HIGH_DISABLED) & irq_s2_q[high_vec_q];
wire nmi_busy = flags_q[`BIT_UNMASKABLE_EXECUTING];
wire high_busy = flags_q[`BIT_HIGH_LEVEL_EXECUTING];
wire normal_busy = flags_q[`BIT_NORMAL_LEVEL_EXECUTING];
reg [1:0] take;
reg [7:0] take_vec;
always @* begin
    take = 2'd0;
    take_vec = 8'h00;
    if (nmi_s2_q && !nmi_busy) begin
        take = 2'd3;
        take_vec = `CVT_UNMASKABLE;
    end else if (high_pend && !nmi_busy && !high_busy) begin
        take = 2'd2;
        take_vec = high_vec_q;
    end else if (normal_pend && !nmi_busy && !high_busy && !normal_busy) begin
        take = 2'd1;
        take_vec = normal_win;
    end
end
// =====================================================================
// apb handshake
// ready follows setup by one cycle, so no transfer ever waits longer
always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
        PREADY <= 1'b0;
        PSLVERR <= 1'b0;
        PRDATA <= 32'h0;
    end else begin
        PREADY <= setup;
        PSLVERR <= setup & ~known;
        if (rd) begin
            PRDATA <= rd_word;
        end
    end
end
// =====================================================================
// read data selection
// the key register reads as zero, so the key never leaks back
always @* begin
    rd_word = 32'h0;
    if (sel_ctrl) begin
        rd_word = {24'h0, ctrl_q};
    end else if (sel_flags) begin
        rd_word = {24'h0, flags_q};
    end else if (sel_ptr) begin
        rd_word = {24'h0, pointer_q};
    end else if (sel_high) begin
        rd_word = {24'h0, high_vec_q};
    end else begin
        rd_word = 32'h0;
    end
end
// =====================================================================
// unlock window
// window counts retired instructions
always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
        unlock_q <= 3'h0;
    end else begin
        if (wr && sel_key && PWDATA[7:0] == `IO_REGISTER_KEY) begin
            unlock_q <= `UNLOCK_WINDOW;
        end else if (wr && sel_ctrl) begin
            // one protected write uses up the window
            unlock_q <= 3'h0;
        end else if (unlock_q != 3'h0 && INSTR_RETIRE) begin
            unlock_q <= unlock_q - 3'h1;
        end
    end
end
// =====================================================================
// control register
always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
        ctrl_q <= `RST_INTERRUPT_CONTROL;
    end else begin
        if (wr && sel_ctrl) begin
            ctrl_q[`BIT_ROUND_ROBIN_ENABLE] <= PWDATA[`BIT_ROUND_ROBIN_ENABLE];
            if (unlock_q != 3'h0) begin
                ctrl_q[`BIT_VECTOR_LOCATION_SELECT] <= PWDATA[`BIT_VECTOR_LOCATION_SELECT];
                ctrl_q[`BIT_COMPACT_TABLE_ENABLE] <= PWDATA[`BIT_COMPACT_TABLE_ENABLE];
            end
        end
    end
end
// =====================================================================
// high priority vector
// any write value accepted, zero disables
always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
        high_vec_q <= `RST_HIGH_PRIORITY_VECTOR;
    end else begin
        if (wr && sel_high) begin
            high_vec_q <= PWDATA[7:0];
        end
    end
end
// =====================================================================
// normal priority pointer
// loads the real vector number, not the compact table slot
always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
        pointer_q <= `RST_NORMAL_PRIORITY_POINTER;
    end else begin
        if (CPU_ACK && IRQ_VALID && IRQ_SLOT == 8'h01 && ctrl_q[`BIT_ROUND_ROBIN_ENABLE]) begin
            pointer_q <= taken_num_q;
        end else if (wr && sel_ptr) begin
            pointer_q <= PWDATA[7:0];
        end
    end
end
// =====================================================================
// vector location and restart address
always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
        VECTORS_AT_BOOT_START <= 1'b0;
        RESET_VECTOR_PC <= `RESET_PC;
    end else begin
        VECTORS_AT_BOOT_START <= ctrl_q[`BIT_VECTOR_LOCATION_SELECT] & ~ALL_BOOT;
        RESET_VECTOR_PC <= `RESET_PC;
    end
end
// =====================================================================
// executing flags
// an ack and a return in one cycle lose the return; the core never does both
always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
        flags_q <= `RST_LEVEL_EXECUTING_FLAGS;
    end else begin
        if (CPU_ACK && IRQ_VALID) begin
            case (IRQ_SLOT)
                8'h03: flags_q[`BIT_UNMASKABLE_EXECUTING] <= 1'b1;
                8'h02: flags_q[`BIT_HIGH_LEVEL_EXECUTING] <= 1'b1;
                8'h01: flags_q[`BIT_NORMAL_LEVEL_EXECUTING] <= 1'b1;
                default: flags_q <= flags_q;
            endcase
        end else if (INTERRUPT_RETURN) begin
            if (nmi_busy) begin
                flags_q[`BIT_UNMASKABLE_EXECUTING] <= 1'b0;
            end else if (high_busy) begin
                flags_q[`BIT_HIGH_LEVEL_EXECUTING] <= 1'b0;
            end else begin
                flags_q[`BIT_NORMAL_LEVEL_EXECUTING] <= 1'b0;
            end
        end
    end
end
// =====================================================================
// presentation to the core
// request held until acknowledged; a higher level may replace it first
always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
        IRQ_VALID <= 1'b0;
        IRQ_VECTOR <= 8'h00;
        IRQ_SLOT <= 8'h00;
        taken_num_q <= 8'h00;
    end else begin
        if (CPU_ACK && IRQ_VALID) begin
            IRQ_VALID <= 1'b0;
            IRQ_SLOT <= 8'h00;
        end else if (INTERRUPT_RETURN) begin
            // flags change this cycle, so arbitration waits one cycle
            IRQ_VALID <= IRQ_VALID;
        end else if (take != 2'd0 && (!IRQ_VALID || {6'h0, take} > IRQ_SLOT)) begin
            IRQ_VALID <= 1'b1;
            IRQ_SLOT <= {6'h0, take};
            taken_num_q <= take_vec;
            if (ctrl_q[`BIT_COMPACT_TABLE_ENABLE]) begin
                IRQ_VECTOR <= (take == 2'd3) ? `CVT_UNMASKABLE :
                    (take == 2'd2) ? `CVT_HIGH : `CVT_NORMAL;
            end else begin
                IRQ_VECTOR <= take_vec;
            end
        end
    end
end

endmodule // cpu_interrupt_controller
`default_nettype wire

/* irq_ctrl_checker.sv */
// assertion checker for the interrupt priority control block
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl_checker (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic CPU_ACK,
    input wire logic ALL_BOOT,
    input wire logic IRQ_VALID,
    input wire logic [7:0] IRQ_SLOT,
    input wire logic VECTORS_AT_BOOT_START,
    input wire logic [15:0] RESET_VECTOR_PC
);
    // ====================
    // properties
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    sequence setup_s;
        PSEL && !PENABLE;
    endsequence
    AST_READY: assert property (setup_s |=> PREADY) else $error("no ready");
    AST_RDY_PULSE: assert property (PREADY |=> !PREADY) else $error("ready held");
    AST_UNMAPPED: assert property (setup_s ##0 PADDR > 8'h10 |=> PSLVERR) else $error("no err");
    AST_UPPER: assert property (PREADY |-> PRDATA[31:8] == 24'h0) else $error("upper bits");
    AST_PC: assert property (RESET_VECTOR_PC == 16'h0000) else $error("reset pc");
    AST_BOOT: assert property (ALL_BOOT |=> !VECTORS_AT_BOOT_START) else $error("location");
    AST_ACK: assert property (IRQ_VALID && CPU_ACK |=> !IRQ_VALID) else $error("ack");
    AST_HOLD: assert property (IRQ_VALID && !CPU_ACK |=> IRQ_VALID) else $error("dropped");
    AST_SLOT: assert property (IRQ_VALID |-> IRQ_SLOT inside {8'h01, 8'h02, 8'h03})
        else $error("slot");
endmodule // irq_ctrl_checker
bind cpu_interrupt_controller irq_ctrl_checker i_chk (.CORE_CLK(CORE_CLK), .RST(RST),
    .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .CPU_ACK(CPU_ACK), .ALL_BOOT(ALL_BOOT), .IRQ_VALID(IRQ_VALID),
    .IRQ_SLOT(IRQ_SLOT), .VECTORS_AT_BOOT_START(VECTORS_AT_BOOT_START),
    .RESET_VECTOR_PC(RESET_VECTOR_PC));
`default_nettype wire

/* cpu_core_model.sv */
// cpu core model that acknowledges presented interrupts
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic irq_valid,
    input wire logic [3:0] ack_delay,
    output logic cpu_ack
);
    // ====================
    // acknowledge after a chosen pause, so slow cores are covered too
    logic [3:0] wait_q;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            wait_q <= 4'h0;
            cpu_ack <= 1'b0;
        end else begin
            wait_q <= irq_valid ? wait_q + 4'h1 : 4'h0;
            cpu_ack <= irq_valid && !cpu_ack && wait_q >= ack_delay;
        end
    end
endmodule // cpu_core_model
`default_nettype wire

/* tb_cpu_interrupt_controller.sv */
// self-checking bench of the interrupt priority control block
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_interrupt_controller;
    // ====================
    // stimulus and checks
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, ret = 0, retire = 0, boot = 0, nmi = 0;
    logic pready, pslverr, ack, valid, atboot, err;
    logic [7:0] paddr = 8'h00, vec, slot;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [255:0] req = '0;
    logic [15:0] pc;
    int n_errors = 0, checks_done = 0;
    // rows: write flag, address, write data, expected read data
    logic [24:0] rows [15] = '{25'h0_00_00_00, 25'h0_04_00_00, 25'h0_08_00_00, 25'h0_0c_00_00,
        25'h1_00_61_00, 25'h0_00_00_01, 25'h1_04_ff_00, 25'h0_04_00_00, 25'h1_08_05_00,
        25'h0_08_00_05, 25'h1_0c_07_00, 25'h0_0c_00_07, 25'h0_14_00_00, 25'h1_00_00_00,
        25'h0_00_00_00};
    always #4 clk = ~clk;
    cpu_interrupt_controller i_dut (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .IRQ_REQ(req), .UNMASKABLE_REQ(nmi), .INSTR_RETIRE(retire),
        .INTERRUPT_RETURN(ret), .CPU_ACK(ack), .ALL_BOOT(boot), .IRQ_VALID(valid),
        .IRQ_VECTOR(vec), .IRQ_SLOT(slot), .VECTORS_AT_BOOT_START(atboot),
        .RESET_VECTOR_PC(pc));
    cpu_core_model i_cpu (.clk(clk), .rst(rst), .irq_valid(valid), .ack_delay(4'h2),
        .cpu_ack(ack));
    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic guard(input int k);
        if (k >= 50) begin
            n_errors++;
            end_of_test;
        end
    endtask
    // one transfer, then an idle cycle so no strobe is driven twice in a step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
        output logic [31:0] rd);
        int k;
        psel <= 1'b1;
        pwr <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        guard(k);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] d;
        apb(1'b0, a, 8'h00, d);
        chk("register", {24'h0, e}, d);
    endtask
    // wait for a presentation, check it, then wait for the core to take it
    task automatic irq(input logic [7:0] v, input logic [7:0] s);
        int k;
        k = 0;
        while (valid !== 1'b1 && k < 50) begin
            @(posedge clk);
            k++;
        end
        guard(k);
        chk("vector", {24'h0, v}, {24'h0, vec});
        chk("slot", {24'h0, s}, {24'h0, slot});
        k = 0;
        while (valid === 1'b1 && k < 50) begin
            @(posedge clk);
            k++;
        end
        guard(k);
    endtask
    task automatic pulse_ret;
        ret <= 1'b1;
        @(posedge clk);
        ret <= 1'b0;
        @(posedge clk);
    endtask
    initial begin
        logic [31:0] d;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        foreach (rows[i]) begin
            apb(rows[i][24], rows[i][23:16], rows[i][15:8], d);
            if (!rows[i][24]) begin
                chk("read data", {24'h0, rows[i][7:0]}, d);
                chk("slave error", {31'h0, rows[i][23:16] == 8'h14}, {31'h0, err});
            end
        end
        req[4] <= 1'b1;
        req[6] <= 1'b1;
        req[9] <= 1'b1;
        irq(8'h06, 8'h01);
        req[6] <= 1'b0;
        req[7] <= 1'b1;
        irq(8'h07, 8'h02);
        req[7] <= 1'b0;
        rd_chk(8'h04, 8'h03);
        pulse_ret();
        rd_chk(8'h04, 8'h01);
        pulse_ret();
        irq(8'h09, 8'h01);
        req[9] <= 1'b0;
        repeat (2) @(posedge clk);
        pulse_ret();
        irq(8'h04, 8'h01);
        req[4] <= 1'b0;
        repeat (2) @(posedge clk);
        pulse_ret();
        rd_chk(8'h04, 8'h00);
        apb(1'b1, 8'h10, 8'hd8, d);
        retire <= 1'b1;
        @(posedge clk);
        retire <= 1'b0;
        apb(1'b1, 8'h00, 8'h61, d);
        rd_chk(8'h00, 8'h61);
        chk("boot start", 32'h1, {31'h0, atboot});
        boot <= 1'b1;
        repeat (2) @(posedge clk);
        chk("boot start", 32'h0, {31'h0, atboot});
        boot <= 1'b0;
        req[9] <= 1'b1;
        irq(8'h03, 8'h01);
        req[9] <= 1'b0;
        rd_chk(8'h08, 8'h09);
        pulse_ret();
        nmi <= 1'b1;
        irq(8'h01, 8'h03);
        nmi <= 1'b0;
        rd_chk(8'h04, 8'h80);
        pulse_ret();
        rd_chk(8'h04, 8'h00);
        apb(1'b1, 8'h00, 8'h00, d);
        rd_chk(8'h00, 8'h60);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_chk(8'h00, 8'h00);
        chk("reset pc", 32'h0, {16'h0, pc});
        end_of_test;
    end
endmodule // tb_cpu_interrupt_controller
`default_nettype wire
